// *** rtl/sfspi_front_end.sv ***
/*
 * serial flash bus front end: pin synchronisers, framing by select, bit shifting
 * in on clock rise and out on clock fall (1, 2 or 4 lines), hold, standby,
 * program byte counting, erase alignment and security page locks.
 * assumes the serial clock is well below mclk/6 and the command layer sits
 * on the user side.
 */
`timescale 1ns/1ns
module sfspi_front_end (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] data_lines_quad_i,
   output logic [3:0] data_lines_quad_o,
   output logic [3:0] data_lines_quad_oe,
   output sfspi_pkg::sfspi_rx_t rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_overrun,
   input wire sfspi_pkg::sfspi_tx_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic busy,
   output logic selected,
   output logic standby,
   output logic frame_start,
   output logic frame_end,
   input wire logic prog_byte,
   output logic [8:0] prog_count,
   output logic prog_page_over,
   input wire logic erase_req,
   input wire sfspi_pkg::sfspi_erase_t erase_size,
   input wire logic [sfspi_pkg::ADDR_W-1:0] erase_addr,
   output logic erase_go,
   output logic [sfspi_pkg::ADDR_W-1:0] erase_base,
   input wire logic sec_lock_req,
   input wire logic [1:0] sec_page,
   output logic [sfspi_pkg::SEC_PAGES-1:0] sec_locked
);
   import sfspi_pkg::*;

   logic [PIN_N-1:0] pins;
   logic [PIN_N-1:0] s1_q, s2_q, s3_q, filt_q, chg;

   assign pins = {cs_n, sck, data_lines_quad_i};

   // three-stage synchronisers; a change counts when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         assign chg[gi] = (s2_q[gi] == s3_q[gi]) && (s3_q[gi] != filt_q[gi]);
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               s1_q[gi] <= PIN_RESET[gi];
               s2_q[gi] <= PIN_RESET[gi];
               s3_q[gi] <= PIN_RESET[gi];
               filt_q[gi] <= PIN_RESET[gi];
            end else begin
               s1_q[gi] <= pins[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (chg[gi]) begin
                  filt_q[gi] <= s3_q[gi];
               end
            end
         end
      end
   endgenerate

   logic cs_fall, cs_rise, sel, sck_rise, sck_fall, hold, rx_step, tx_step;
   logic tx_on_q;
   sfspi_width_t width_q;

   assign cs_fall = chg[PIN_CS] && !s3_q[PIN_CS];
   assign cs_rise = chg[PIN_CS] && s3_q[PIN_CS];
   assign sel = !filt_q[PIN_CS] && !cs_rise;
   // line three is hold except while it carries quad data
   assign hold = !filt_q[PIN_IO3] && !(tx_on_q && width_q == SFSPI_W4);
   // edges count whichever level the clock idled at
   assign sck_rise = chg[PIN_SCK] && s3_q[PIN_SCK];
   assign sck_fall = chg[PIN_SCK] && !s3_q[PIN_SCK];
   assign rx_step = sck_rise && sel && !hold && !data_lines_quad_oe[PIN_IO0];
   assign tx_step = sck_fall && sel && !hold;

   assign selected = sel;
   // self-timed work keeps the part active after deselect
   assign standby = filt_q[PIN_CS] && !busy;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frame_start <= 1'b0;
         frame_end <= 1'b0;
      end else begin
         frame_start <= cs_fall;
         frame_end <= cs_rise;
      end
   end

   // receive shifter
   logic [6:0] rsh_q;
   logic [2:0] rcnt_q;
   logic first_q;
   logic push, in_ready;
   sfspi_rx_t push_word;

   assign push = rx_step && rcnt_q == 3'h7;
   assign push_word = '{data: {rsh_q, filt_q[PIN_IO0]}, first: first_q};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rsh_q <= 7'h00;
         rcnt_q <= 3'h0;
         first_q <= 1'b1;
      end else if (cs_fall) begin
         rcnt_q <= 3'h0;
         first_q <= 1'b1;
      end else if (rx_step) begin
         rsh_q <= {rsh_q[5:0], filt_q[PIN_IO0]};
         rcnt_q <= rcnt_q + 3'h1;
         if (push) begin
            first_q <= 1'b0;
         end
      end
   end

   // byte lost only when the user side has let both entries fill
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_overrun <= 1'b0;
      end else if (push && !in_ready) begin
         rx_overrun <= 1'b1;
      end else if (cs_fall) begin
         rx_overrun <= 1'b0;
      end
   end

   // two-entry buffer toward the command layer
   sfspi_rx_t mem_q [2];
   logic wp_q, rp_q;
   logic [1:0] cnt_q;
   logic wr, rd;

   assign in_ready = cnt_q != 2'h2;
   assign wr = push && in_ready;
   assign rd = rx_valid && rx_ready;
   assign rx_valid = cnt_q != 2'h0;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else if (wr) begin
         mem_q[wp_q] <= push_word;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (wr) begin
            wp_q <= !wp_q;
         end
         if (rd) begin
            rp_q <= !rp_q;
         end
         case ({wr, rd})
            2'b10: cnt_q <= cnt_q + 2'h1;
            2'b01: cnt_q <= cnt_q - 2'h1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

   // a word entering an empty buffer, or landing behind the one being read, bypasses the array
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_data <= '0;
      end else if (wr && (cnt_q == 2'h0 || (cnt_q == 2'h1 && rd))) begin
         rx_data <= push_word;
      end else begin
         rx_data <= mem_q[rd ? !rp_q : rp_q];
      end
   end

   // transmit shifter
   logic [7:0] tsh_q;
   logic [3:0] left_q, step, tstep;
   logic [3:0] out_q;
   logic load;

   always_comb begin
      step = 4'h1;
      case (width_q)
         SFSPI_W2: step = 4'h2;
         SFSPI_W4: step = 4'h4;
         default: step = 4'h1;
      endcase
      tstep = 4'h1;
      case (tx_data.width)
         SFSPI_W2: tstep = 4'h2;
         SFSPI_W4: tstep = 4'h4;
         default: tstep = 4'h1;
      endcase
   end

   // next byte only once every bit of the current one has gone out
   assign load = tx_step && left_q == 4'h0;
   assign tx_ready = load && tx_valid;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tsh_q <= 8'h00;
         left_q <= 4'h0;
         out_q <= 4'h0;
         tx_on_q <= 1'b0;
         width_q <= SFSPI_W1;
      end else if (cs_rise || cs_fall) begin
         left_q <= 4'h0;
         tx_on_q <= 1'b0;
         width_q <= SFSPI_W1;
      end else if (load) begin
         tx_on_q <= tx_valid;
         if (tx_valid) begin
            width_q <= tx_data.width;
            tsh_q <= tx_data.data << tstep;
            left_q <= BITS_BYTE - tstep;
            case (tx_data.width)
               SFSPI_W2: out_q <= {2'b00, tx_data.data[7:6]};
               SFSPI_W4: out_q <= tx_data.data[7:4];
               default: out_q <= {2'b00, tx_data.data[7], 1'b0};
            endcase
         end else begin
            left_q <= 4'h0;
         end
      end else if (tx_step) begin
         tsh_q <= tsh_q << step;
         left_q <= left_q - step;
         case (width_q)
            SFSPI_W2: out_q <= {2'b00, tsh_q[7:6]};
            SFSPI_W4: out_q <= tsh_q[7:4];
            default: out_q <= {2'b00, tsh_q[7], 1'b0};
         endcase
      end
   end

   // released while deselected, on hold or with nothing to send
   always_comb begin
      data_lines_quad_oe = 4'h0;
      if (sel && !hold && tx_on_q) begin
         case (width_q)
            SFSPI_W2: data_lines_quad_oe = OE_DUAL;
            SFSPI_W4: data_lines_quad_oe = OE_QUAD;
            default: data_lines_quad_oe = OE_SINGLE;
         endcase
      end
   end
   assign data_lines_quad_o = out_q;

   // program data bytes, one to a full page per command
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prog_count <= 9'h000;
         prog_page_over <= 1'b0;
      end else if (cs_fall) begin
         prog_count <= 9'h000;
         prog_page_over <= 1'b0;
      end else if (prog_byte && sel) begin
         if (prog_count == PAGE_BYTES) begin
            prog_page_over <= 1'b1;
         end else begin
            prog_count <= prog_count + 9'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         erase_go <= 1'b0;
         erase_base <= '0;
      end else begin
         erase_go <= erase_req;
         if (erase_req) begin
            erase_base <= sfspi_align(erase_addr, erase_size);
         end
      end
   end

   generate
      for (gi = 0; gi < SEC_PAGES; gi++) begin : g_lock
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               sec_locked[gi] <= 1'b0;
            end else if (sec_lock_req && sec_page == 2'(gi)) begin
               sec_locked[gi] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule : sfspi_front_end

// *** rtl/sfspi_pkg.sv ***
/*
 * constants, types and the behaviour list of the serial flash bus front end.
 * assumes a single mclk domain; pins arrive unsynchronised.
 */
// Behaviour
// - select high deselects the device; it then enters standby, never deep power-down.
// - while deselected every data line output is released.
// - while deselected input line values are ignored; no bits are accepted.
// - operations start on select falling edge and end on its rising edge.
// - a self-timed cycle launched at deselect delays standby until it finishes.
// - input bits are sampled on each serial clock rising edge.
// - output bits change only on serial clock falling edges.
// - dual and quad reads turn line zero into an output, two or four bits.
// - serial clock may idle low or high; modes 0 and 3 only.
// - a program accepts one to 256 data bytes within one page.
// - erase aligned 4, 32 or 64 Kbyte blocks, or the whole array.
// - three security pages, each lockable on its own, permanently.
// - hold ignores clock and input, floats output, keeps selection and state.
// - quad reads drive lines two and three too, four bits per clock.
package sfspi_pkg;
   localparam int PIN_N = 6;
   localparam int PIN_CS = 5;
   localparam int PIN_SCK = 4;
   localparam int PIN_IO3 = 3;
   localparam int PIN_IO0 = 0;
   localparam logic [PIN_N-1:0] PIN_RESET = 6'h2F;
   localparam int ADDR_W = 19;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam int SEC_PAGES = 3;
   localparam logic [ADDR_W-1:0] MASK_4K = 19'h7F000;
   localparam logic [ADDR_W-1:0] MASK_32K = 19'h78000;
   localparam logic [ADDR_W-1:0] MASK_64K = 19'h70000;
   localparam logic [ADDR_W-1:0] MASK_CHIP = 19'h00000;
   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [3:0] OE_QUAD = 4'hF;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   typedef enum logic [1:0] {SFSPI_W1, SFSPI_W2, SFSPI_W4} sfspi_width_t;
   typedef enum logic [1:0] {SFSPI_E4K, SFSPI_E32K, SFSPI_E64K, SFSPI_ECHIP} sfspi_erase_t;

   typedef struct packed {
      logic [7:0] data;
      logic first;
   } sfspi_rx_t;

   typedef struct packed {
      logic [7:0] data;
      sfspi_width_t width;
   } sfspi_tx_t;

   function automatic logic [ADDR_W-1:0] sfspi_align(input logic [ADDR_W-1:0] a,
                                                     input sfspi_erase_t s);
      logic [ADDR_W-1:0] m;
      m = MASK_CHIP;
      case (s)
         SFSPI_E4K: m = MASK_4K;
         SFSPI_E32K: m = MASK_32K;
         SFSPI_E64K: m = MASK_64K;
         default: m = MASK_CHIP;
      endcase
      return a & m;
   endfunction : sfspi_align
endpackage : sfspi_pkg

// *** verification/sfspi_host_model.sv ***
/* host controller model for the serial flash front end bench.
   assumes the bench resolves the four data pins and feeds them back. */
`timescale 1ns/1ns
module sfspi_host_model (
   input wire logic mclk,
   input wire logic [3:0] pins,
   output logic cs_n,
   output logic sck,
   output logic [3:0] io_v,
   output logic [3:0] io_oe
);
   initial begin
      cs_n = 1'h1;
      sck = 1'h0;
      io_v = 4'hF;
      io_oe = 4'h9;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   task automatic sel(input logic idle);
      sck = idle;
      wt(6);
      cs_n = 1'h0;
      wt(8);
   endtask : sel
   task automatic desel();
      wt(6);
      cs_n = 1'h1;
      io_oe = 4'h9;
      wt(8);
   endtask : desel
   // hold only starts with the clock low
   task automatic hold(input logic on);
      io_v[3] = !on;
   endtask : hold
   task automatic put(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sck = 1'h0;
         io_v[0] = b[i];
         wt(6);
         sck = 1'h1;
         wt(6);
      end
      sck = 1'h0;
      wt(6);
   endtask : put
   // bits are taken as the clock rises
   task automatic get(input int w, output logic [7:0] v);
      io_oe = 4'h0;
      v = 8'h00;
      for (int i = 0; i < 8 / w; i++) begin
         sck = 1'h0;
         wt(6);
         sck = 1'h1;
         v = (w == 1) ? {v[6:0], pins[1]} : (w == 2) ? {v[5:0], pins[1:0]} : {v[3:0], pins};
         wt(6);
      end
   endtask : get
endmodule : sfspi_host_model

// *** verification/sfspi_front_end_asserts.sv ***
/* port checker for the serial flash front end.
   assumes one mclk domain; bound onto every front end instance. */
`timescale 1ns/1ns
module sfspi_front_end_asserts (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic selected,
   input wire logic standby,
   input wire logic busy,
   input wire logic [3:0] data_lines_quad_o,
   input wire logic [3:0] data_lines_quad_oe,
   input wire logic rx_valid,
   input wire logic frame_start,
   input wire logic frame_end,
   input wire logic prog_byte,
   input wire logic [8:0] prog_count,
   input wire logic prog_page_over
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence s_idle;
      !selected [*3] ##0 !rx_valid;
   endsequence
   property p_busy;
      busy |-> !standby;
   endproperty
   property p_oe;
      !selected |-> data_lines_quad_oe == 4'h0;
   endproperty
   property p_ign;
      s_idle |=> !rx_valid;
   endproperty
   property p_fs;
      $rose(selected) |-> ##[0:2] frame_start;
   endproperty
   property p_fe;
      $fell(selected) |-> ##[0:2] frame_end;
   endproperty
   property p_fall;
      selected && $past(selected) && $changed(data_lines_quad_o) |-> !sck;
   endproperty
   property p_cnt;
      selected && prog_byte && prog_count < 9'h100 |=> prog_count == $past(prog_count) + 9'h1;
   endproperty
   property p_over;
      selected && prog_byte && prog_count == 9'h100 |=> prog_page_over;
   endproperty
   a_busy: assert property (p_busy) else $error("standby while busy");
   a_oe: assert property (p_oe) else $error("lines driven while deselected");
   a_ign: assert property (p_ign) else $error("byte taken while deselected");
   a_fs: assert property (p_fs) else $error("no frame start");
   a_fe: assert property (p_fe) else $error("no frame end");
   a_fall: assert property (p_fall) else $error("output moved with clock high");
   a_cnt: assert property (p_cnt) else $error("program count not stepped");
   a_over: assert property (p_over) else $error("page overflow not flagged");
endmodule : sfspi_front_end_asserts

bind sfspi_front_end sfspi_front_end_asserts u_chk (.mclk, .nrst, .sck, .selected, .standby,
   .busy, .data_lines_quad_o, .data_lines_quad_oe, .rx_valid, .frame_start, .frame_end,
   .prog_byte, .prog_count, .prog_page_over);

// *** verification/serial_flash_spi_front_end_bench.sv ***
/* self-checking bench for the serial flash front end.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module serial_flash_spi_front_end_bench;
   import sfspi_pkg::*;
   logic mclk, nrst, tog = 1'h0, rx_ready, tx_valid;
   logic busy, prog_byte, erase_req, sec_lock_req;
   logic [1:0] sec_page;
   logic [ADDR_W-1:0] erase_addr;
   sfspi_erase_t erase_size;
   sfspi_tx_t tx_data;
   sfspi_rx_t rx_data;
   sfspi_rx_t rxq[$];
   logic cs_n, sck, rx_valid, rx_overrun, tx_ready, selected, standby, frame_start, frame_end;
   logic prog_page_over, erase_go;
   logic [3:0] dq_o, oe, pins, h_v, h_oe;
   logic [8:0] prog_count;
   logic [ADDR_W-1:0] erase_base;
   logic [2:0] sec_locked;
   logic [7:0] v;
   int num_errors = 0, tests_run = 0, n_ld = 0, n_fs = 0, n_fe = 0;

   always #25 mclk = ~mclk;
   // released data lines: pull-up on lines two and three, a moving pattern elsewhere
   assign pins = (oe & dq_o) | (~oe & h_oe & h_v) | (~oe & ~h_oe & {2'h3, tog, tog});
   always @(posedge mclk) begin
      tog <= ~tog;
      if (rx_valid && rx_ready) rxq.push_back(rx_data);
      if (tx_ready) n_ld++;
      if (frame_start) n_fs++;
      if (frame_end) n_fe++;
   end

   sfspi_host_model host (.mclk, .pins, .cs_n, .sck, .io_v(h_v), .io_oe(h_oe));
   sfspi_front_end dut (.mclk, .nrst, .cs_n, .sck, .data_lines_quad_i(pins),
      .data_lines_quad_o(dq_o), .data_lines_quad_oe(oe), .rx_data, .rx_valid, .rx_ready,
      .rx_overrun, .tx_data, .tx_valid, .tx_ready, .busy, .selected, .standby, .frame_start,
      .frame_end, .prog_byte, .prog_count, .prog_page_over, .erase_req, .erase_size,
      .erase_addr, .erase_go, .erase_base, .sec_lock_req, .sec_page, .sec_locked);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic expect_rx(input int n, input logic [26:0] e);
      chk("rx count", n, rxq.size());
      for (int i = 0; i < n && i < rxq.size(); i++) chk("rx byte", e[26-9*i -: 9], rxq[i]);
      rxq.delete();
   endtask : expect_rx
   task automatic pulse(ref logic s);
      s = 1'h1;
      host.wt(1);
      s = 1'h0;
   endtask : pulse
   task automatic close_out();
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   task automatic t_idle();
      chk("locks", 32'h0, sec_locked);
      host.put(8'hFF, 8);
      chk("rx count", 32'h0, rxq.size());
      chk("oe", 32'h0, oe);
      chk("standby", 32'h1, standby);
      chk("selected", 32'h0, selected);
      busy = 1'h1;
      host.wt(2);
      chk("standby busy", 32'h0, standby);
      busy = 1'h0;
   endtask : t_idle
   task automatic t_write();
      host.sel(1'h0);
      chk("selected", 32'h1, selected);
      host.put(8'hA5, 8);
      host.put(8'h3C, 8);
      host.put(8'hE0, 3);
      host.desel();
      host.sel(1'h0);
      host.put(8'h81, 8);
      host.desel();
      expect_rx(3, {8'hA5, 1'h1, 8'h3C, 1'h0, 8'h81, 1'h1});
   endtask : t_write
   task automatic t_hold();
      host.sel(1'h0);
      host.put(8'hC0, 4);
      host.hold(1'h1);
      host.put(8'hF0, 4);
      host.hold(1'h0);
      host.put(8'h60, 4);
      host.desel();
      expect_rx(1, {8'hC6, 1'h1, 18'h0});
   endtask : t_hold
   task automatic t_overrun();
      rx_ready = 1'h0;
      host.sel(1'h0);
      host.put(8'h11, 8);
      host.put(8'h22, 8);
      host.put(8'h33, 8);
      chk("overrun", 32'h1, rx_overrun);
      rx_ready = 1'h1;
      host.desel();
      expect_rx(2, {8'h11, 1'h1, 8'h22, 1'h0, 9'h0});
      host.sel(1'h0);
      chk("overrun cleared", 32'h0, rx_overrun);
      host.desel();
   endtask : t_overrun
   task automatic t_read();
      logic [7:0] d[3] = '{8'hB4, 8'h5A, 8'hE1};
      sfspi_width_t w[3] = '{SFSPI_W1, SFSPI_W2, SFSPI_W4};
      int n[3] = '{1, 2, 4};
      for (int i = 0; i < 3; i++) begin
         tx_data.data = d[i];
         tx_data.width = w[i];
         tx_valid = 1'h1;
         n_ld = 0;
         host.sel(1'h1);
         host.get(n[i], v);
         host.desel();
         tx_valid = 1'h0;
         chk("read", d[i], v);
         chk("loads", 32'h1, n_ld);
      end
      rxq.delete();
   endtask : t_read
   task automatic t_count();
      logic [ADDR_W-1:0] ex[4] = '{19'h5A000, 19'h58000, 19'h50000, 19'h00000};
      logic [1:0] pg[3] = '{2'h1, 2'h0, 2'h2};
      logic [2:0] lk[3] = '{3'h2, 3'h3, 3'h7};
      for (int i = 0; i < 4; i++) begin
         erase_size = sfspi_erase_t'(i);
         pulse(erase_req);
         chk("erase go", 32'h1, erase_go);
         chk("erase base", ex[i], erase_base);
      end
      for (int i = 0; i < 3; i++) begin
         sec_page = pg[i];
         pulse(sec_lock_req);
         host.wt(1);
         chk("locks", lk[i], sec_locked);
      end
      host.sel(1'h0);
      for (int i = 0; i < 257; i++) begin
         if (i == 256) chk("page over early", 32'h0, prog_page_over);
         pulse(prog_byte);
         host.wt(1);
      end
      chk("prog count", 32'h100, prog_count);
      chk("page over", 32'h1, prog_page_over);
      host.desel();
      host.sel(1'h0);
      chk("prog count cleared", 32'h0, prog_count);
      chk("page over cleared", 32'h0, prog_page_over);
      host.desel();
   endtask : t_count

   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      close_out();
   end
   initial begin
      mclk = 1'h0;
      nrst = 1'h0;
      rx_ready = 1'h1;
      tx_valid = 1'h0;
      busy = 1'h0;
      prog_byte = 1'h0;
      erase_req = 1'h0;
      sec_lock_req = 1'h0;
      sec_page = 2'h0;
      erase_addr = 19'h5ABCD;
      erase_size = SFSPI_E4K;
      tx_data = '0;
      repeat (5) @(negedge mclk);
      nrst = 1'h1;
      host.wt(4);
      t_idle();
      t_write();
      t_hold();
      t_overrun();
      t_read();
      t_count();
      chk("frame starts", 32'hA, n_fs);
      chk("frame ends", 32'hA, n_fe);
      close_out();
   end
endmodule : serial_flash_spi_front_end_bench
